// [bench/sac_analog_model.sv]
// behavioural sample-hold, comparator and ladder
`timescale 1ns/100ps
`default_nettype none
module sac_analog_model
   import sac_pkg::*;
(
   input  wire logic           core_clk,
   input  wire sac_analog_t    analog_ctl,
   input  wire logic [7:0][9:0] vin,
   output logic                comparator_high
);
   logic [9:0] held_q;
   logic       last_q = 1'b0;
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 8; i++)
         if (analog_ctl.sample && analog_ctl.chan_onehot[i]) held_q <= vin[i];
      last_q <= comparator_high;
   end
   // toggles outside hold so a stray read is caught
   assign comparator_high = analog_ctl.hold ? held_q >= analog_ctl.tap : !last_q;
endmodule
`default_nettype wire

// [bench/sac_props.sv]
// assertions on the converter control ports
`timescale 1ns/100ps
`default_nettype none
module sac_props
   import sac_pkg::*;
#(parameter int REF_SETTLE_CYC = 8)
(
   input wire logic         core_clk,
   input wire logic         reset,
   input wire sac_bus_req_t bus_req,
   input wire logic [15:0]  bus_rdata,
   input wire sac_analog_t  analog_ctl,
   input wire logic [7:0]   port_pin_digital_en,
   input wire logic         conversion_done_irq,
   input wire logic         reference_ready
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire logic reg_wr = bus_req.wr && bus_req.addr[15:1] == 15'h7FC0;
   wire logic wide_rd = bus_req.rd && bus_req.wide && bus_req.addr == SAC_ADDR_RESULT_LO;
   sequence s_sample; analog_ctl.sample [*8]; endsequence
   sequence s_quiet; !conversion_done_irq [*8]; endsequence
   property p_pulse; conversion_done_irq |=> !conversion_done_irq; endproperty
   property p_low; wide_rd |=> bus_rdata[5:0] == 6'h00; endproperty
   property p_sample; $rose(analog_ctl.sample) |-> s_sample or ##[0:7] reg_wr; endproperty
   property p_excl; !(analog_ctl.sample && analog_ctl.hold); endproperty
   property p_pins; (analog_ctl.chan_onehot & port_pin_digital_en) == 8'h00; endproperty
   property p_one; $countones(analog_ctl.chan_onehot) <= 1; endproperty
   property p_ref; reference_ready |-> analog_ctl.ref_on; endproperty
   property p_abort; reg_wr |=> s_quiet; endproperty
   property p_msb; $rose(analog_ctl.hold) |-> ##[0:1] analog_ctl.tap == 10'h200; endproperty
   property p_rst; $fell(reset) |-> port_pin_digital_en == 8'hFF && !conversion_done_irq; endproperty
   a_pulse: assert property (p_pulse) else $error("done pulse too long");
   a_low: assert property (p_low) else $error("result low bits set");
   a_sample: assert property (p_sample) else $error("sample window short");
   a_excl: assert property (p_excl) else $error("sample and hold together");
   a_pins: assert property (p_pins) else $error("converting pin left digital");
   a_one: assert property (p_one) else $error("several channels selected");
   a_ref: assert property (p_ref) else $error("ready without reference");
   a_abort: assert property (p_abort) else $error("done after register write");
   a_msb: assert property (p_msb) else $error("first trial not msb");
   a_rst: assert property (p_rst) else $error("outputs not at reset value");
endmodule
bind sac_top sac_props #(.REF_SETTLE_CYC(REF_SETTLE_CYC)) u_props (.core_clk(core_clk),
   .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata), .analog_ctl(analog_ctl),
   .port_pin_digital_en(port_pin_digital_en), .conversion_done_irq(conversion_done_irq),
   .reference_ready(reference_ready));
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench of the converter control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
   $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top
   import sac_pkg::*;
;
   logic            core_clk = 1'b0, reset = 1'b1, trig = 1'b0, rd_seen = 1'b0;
   sac_bus_req_t    bus_req = '0;
   logic [15:0]     bus_rdata, ev;
   sac_analog_t     analog_ctl;
   logic [7:0]      port_en;
   logic            done, ref_rdy, cmp;
   logic [7:0][9:0] vin = '0;
   logic [15:0]     exp_q[$];
   logic [31:0]     seed = 32'h8D14, r;
   int              err_count = 0, samples_checked = 0, n, k;
   logic [2:0]      code_tab[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
   int              len_tab[6] = '{144, 120, 96, 576, 480, 384};
   always #10 core_clk = ~core_clk;
   sac_top #(.REF_SETTLE_CYC(8)) DUT (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .conversion_trigger_pin(trig), .comparator_high(cmp),
      .analog_ctl(analog_ctl), .port_pin_digital_en(port_en), .conversion_done_irq(done),
      .reference_ready(ref_rdy));
   sac_analog_model u_analog (.core_clk(core_clk), .analog_ctl(analog_ctl), .vin(vin),
      .comparator_high(cmp));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic complete_run();
      if (err_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 1'b0,
                     input logic [2:0] s = 3'h0);
      @(posedge core_clk);
      bus_req <= '{1'b0, 1'b1, 1'b0, b, s, d[0], a, d};
      @(posedge core_clk);
      bus_req <= '0;
   endtask
   task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] e);
      @(posedge core_clk);
      exp_q.push_back(e);
      bus_req <= '{1'b1, 1'b0, w, 1'b0, 3'h0, 1'b0, a, 8'h00};
      @(posedge core_clk);
      bus_req <= '0;
   endtask
   task automatic wait_done(output int c);
      c = 0;
      do begin
         @(negedge core_clk);
         c++;
      end while (done !== 1'b1 && c < 2000);
      if (c >= 2000) begin
         err_count++;
         complete_run();
      end
   endtask
   task automatic count_done(input int cyc, output int c);
      c = 0;
      repeat (cyc) begin
         @(negedge core_clk);
         if (done === 1'b1) c++;
      end
   endtask
   // read data checked the cycle after each read
   always @(posedge core_clk) begin
      if (rd_seen) begin
         ev = exp_q.pop_front();
         `CHK(bus_rdata, ev)
      end
      rd_seen <= bus_req.rd;
   end
   initial begin
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      rd(SAC_ADDR_RESULT_LO, 1'b1, 16'h0000);
      rd(SAC_ADDR_MODE, 1'b0, 16'h0000);
      rd(16'hFFAA, 1'b0, 16'h0000);
      wr(SAC_ADDR_CHANNEL, 8'hFD);
      wr(SAC_ADDR_CHANNEL, 8'h01, 1'b1, 3'h1);
      rd(SAC_ADDR_CHANNEL, 1'b0, 16'h0005);
      wr(SAC_ADDR_MODE, 8'h01, 1'b1, 3'h0);
      count_done(20, k);
      `CHK(ref_rdy, 1'b1)
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         vin[i] <= r[9:0];
         wr(SAC_ADDR_CHANNEL, 8'(i));
         wr(SAC_ADDR_MODE, {2'b10, code_tab[i], 3'b001});
         wait_done(n);
         count_done(30, k);
         `CHK(port_en, ~(8'h01 << i))
         wait_done(n);
         wait_done(n);
         `CHK(n >= len_tab[i] && n <= len_tab[i] + 2, 1'b1)
         rd(SAC_ADDR_RESULT_LO, 1'b1, {vin[i], 6'h00});
         rd(SAC_ADDR_RESULT_HI, 1'b0, {8'h00, vin[i][9:2]});
         rd(SAC_ADDR_RESULT_LO, 1'b0, {8'h00, vin[i][1:0], 6'h00});
         count_done(30, k);
         wr(SAC_ADDR_MODE, {2'b00, code_tab[i], 3'b001});
      end
      wr(SAC_ADDR_MODE, 8'h81);
      wait_done(n);
      wr(SAC_ADDR_CHANNEL, 8'h00);
      wait_done(n);
      rd(SAC_ADDR_RESULT_LO, 1'b1, {vin[0], 6'h00});
      count_done(30, k);
      wr(SAC_ADDR_MODE, 8'h01);
      count_done(700, k);
      `CHK(k, 0)
      for (int e = 0; e < 4; e++) begin
         wr(SAC_ADDR_MODE, {5'b11000, 2'(e), 1'b1});
         trig <= 1'b1;
         count_done(700, k);
         `CHK(k, e / 2)
         @(posedge core_clk);
         trig <= 1'b0;
         count_done(700, k);
         `CHK(k, e % 2)
      end
      @(posedge core_clk);
      trig <= 1'b1;
      count_done(40, k);
      wr(SAC_ADDR_CHANNEL, 8'h02);
      count_done(700, k);
      `CHK(k, 0)
      @(posedge core_clk);
      trig <= 1'b0;
      count_done(700, k);
      `CHK(k, 1)
      wr(SAC_ADDR_MODE, 8'h00);
      count_done(2, k);
      `CHK(ref_rdy, 1'b0)
      `CHK(analog_ctl.ref_on, 1'b0)
      complete_run();
   end
endmodule
`default_nettype wire

// [design/sac_edge_det.sv]
// trigger synchroniser and edge detector
`timescale 1ns/100ps
`default_nettype none
module sac_edge_det
   import sac_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       pin,
   input  wire logic [1:0] edge_sel,
   output logic            edge_hit
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic hit;
   } sac_edge_st_t;
   sac_edge_st_t q, d;

   always_comb begin
      d    = q;
      d.s1 = pin;
      d.s2 = q.s1;
      d.s3 = q.s2;
      unique case (edge_sel)
         SAC_EDGE_NONE: d.hit = 1'b0;
         SAC_EDGE_FALL: d.hit = q.s3 & ~q.s2;
         SAC_EDGE_RISE: d.hit = ~q.s3 & q.s2;
         SAC_EDGE_BOTH: d.hit = q.s3 ^ q.s2;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign edge_hit = q.hit;
endmodule
`default_nettype wire

// [design/sac_top.sv]
// converter control: registers, sequencing and approximation
`timescale 1ns/100ps
`default_nettype none
module sac_top
   import sac_pkg::*;
#(
   parameter int REF_SETTLE_CYC = SAC_REF_SETTLE_CYC
)
(
   input  wire logic         core_clk,
   input  wire logic         reset,
   input  wire sac_bus_req_t bus_req,
   output logic [15:0]       bus_rdata,
   input  wire logic         conversion_trigger_pin,
   input  wire logic         comparator_high,
   output sac_analog_t       analog_ctl,
   output logic [7:0]        port_pin_digital_en,
   output logic              conversion_done_irq,
   output logic              reference_ready
);
   // settle counter is 12 bits wide
   if (REF_SETTLE_CYC < 1 || REF_SETTLE_CYC > 4095) begin
      $error("REF_SETTLE_CYC out of range");
   end

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_WAIT   = 2'b01,
      ST_SAMPLE = 2'b10,
      ST_CONV   = 2'b11
   } sac_state_t;

   typedef struct packed {
      sac_state_t  st;
      logic [7:0]  mode;
      logic [2:0]  chan;
      logic [15:0] result;
      logic [9:0]  sar;
      logic [3:0]  bitn;
      logic [9:0]  cnt;
      logic [9:0]  step_cnt;
      logic [11:0] ref_cnt;
      logic        ref_ok;
      logic        irq;
      logic [15:0] rdata;
      sac_analog_t an;
      logic [7:0]  dig_en;
   } sac_top_st_t;

   sac_top_st_t q, d;
   logic        edge_hit;
   logic        conv_en;
   logic        hw_mode;
   logic [9:0]  conv_len;
   logic [9:0]  step_len;
   logic        mode_wr;
   logic        chan_wr;
   logic [7:0]  mode_new;

   sac_edge_det u_edge (
      .core_clk (core_clk),
      .reset    (reset),
      .pin      (conversion_trigger_pin),
      .edge_sel (q.mode[SAC_BIT_EDGE_LO +: 2]),
      .edge_hit (edge_hit)
   );

   // ************************************************************
   // register decode
   // ************************************************************
   always_comb begin
      mode_wr  = bus_req.wr && bus_req.addr == SAC_ADDR_MODE;
      chan_wr  = bus_req.wr && !bus_req.bit_op && bus_req.addr == SAC_ADDR_CHANNEL;
      mode_new = q.mode;
      if (bus_req.bit_op) begin
         mode_new[bus_req.bit_sel] = bus_req.bit_val;
      end else begin
         mode_new = bus_req.wdata;
      end
      conv_en = q.mode[SAC_BIT_ENABLE];
      hw_mode = q.mode[SAC_BIT_HWSTART];
      unique case (q.mode[SAC_BIT_TIME_LO +: 3])
         3'h0:    conv_len = SAC_LEN_144;
         3'h1:    conv_len = SAC_LEN_120;
         3'h2:    conv_len = SAC_LEN_96;
         3'h4:    conv_len = SAC_LEN_576;
         3'h5:    conv_len = SAC_LEN_480;
         3'h6:    conv_len = SAC_LEN_384;
         default: conv_len = SAC_LEN_144;
      endcase
      step_len = 10'((conv_len - SAC_SAMPLE_CYC) / 10'd10);
   end

   // ************************************************************
   // sequencing and approximation
   // ************************************************************
   always_comb begin
      d     = q;
      d.irq = 1'b0;
      if (mode_wr) begin
         d.mode = mode_new;
      end
      if (chan_wr) begin
         d.chan = bus_req.wdata[SAC_CHAN_W-1:0];
      end
      // ready falls in the same cycle as the reference enable
      if (!d.mode[SAC_BIT_REF]) begin
         d.ref_cnt = '0;
         d.ref_ok  = 1'b0;
      end else if (!q.ref_ok) begin
         d.ref_cnt = q.ref_cnt + 12'd1;
         d.ref_ok  = (q.ref_cnt == 12'(REF_SETTLE_CYC - 1));
      end
      unique case (q.st)
         ST_IDLE: begin
            if (conv_en) begin
               d.st = hw_mode ? ST_WAIT : ST_SAMPLE;
               d.cnt = '0;
            end
         end
         ST_WAIT: begin
            if (edge_hit) begin
               d.st  = ST_SAMPLE;
               d.cnt = '0;
            end
         end
         ST_SAMPLE: begin
            d.cnt = q.cnt + 10'd1;
            if (q.cnt == SAC_SAMPLE_CYC - 10'd1) begin
               d.st       = ST_CONV;
               d.bitn     = 4'd9;
               d.sar      = 10'h200;
               d.step_cnt = '0;
            end
         end
         ST_CONV: begin
            d.cnt      = q.cnt + 10'd1;
            d.step_cnt = q.step_cnt + 10'd1;
            if (q.step_cnt == step_len - 10'd1 && q.bitn != 4'hF) begin
               d.step_cnt = '0;
               d.sar[q.bitn] = comparator_high;
               if (q.bitn != 4'd0) begin
                  d.sar[q.bitn - 4'd1] = 1'b1;
               end
               d.bitn = q.bitn - 4'd1;
            end
            if (q.cnt == conv_len - 10'd1) begin
               d.result = {q.sar, {SAC_RES_SHIFT{1'b0}}};
               d.irq    = 1'b1;
               d.cnt    = '0;
               d.st     = hw_mode ? ST_WAIT : ST_SAMPLE;
            end
         end
      endcase
      if (mode_wr || chan_wr) begin
         d.irq = 1'b0;
         d.cnt = '0;
         if (mode_wr ? !mode_new[SAC_BIT_ENABLE] : !conv_en) begin
            d.st = ST_IDLE;
         end else if (mode_wr ? mode_new[SAC_BIT_HWSTART] : hw_mode) begin
            d.st = ST_WAIT;
         end else begin
            d.st = ST_SAMPLE;
         end
      end else if (!conv_en) begin
         d.st  = ST_IDLE;
         d.irq = 1'b0;
         d.result = q.result;
      end
      d.an.sample = (d.st == ST_SAMPLE);
      d.an.hold   = (d.st == ST_CONV);
      d.an.ref_on = d.mode[SAC_BIT_REF];
      d.an.tap    = d.sar;
      d.an.chan_onehot = (d.st != ST_IDLE) ? 8'(8'h01 << d.chan) : 8'h00;
      d.dig_en    = ~d.an.chan_onehot;
      d.rdata     = 16'h0000;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            SAC_ADDR_RESULT_LO: d.rdata = bus_req.wide ? q.result
                                                       : {8'h00, q.result[7:0]};
            SAC_ADDR_RESULT_HI: d.rdata = {8'h00, q.result[15:8]};
            SAC_ADDR_MODE:      d.rdata = {8'h00, q.mode};
            SAC_ADDR_CHANNEL:   d.rdata = {13'h0000, q.chan};
            default:            d.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         q        <= '0;
         q.st     <= ST_IDLE;
         q.mode   <= SAC_MODE_RESET;
         q.chan   <= SAC_CHAN_RESET[2:0];
         q.result <= SAC_RESULT_RESET;
         q.dig_en <= 8'hFF;
      end else begin
         q <= d;
      end
   end

   assign bus_rdata           = q.rdata;
   assign analog_ctl          = q.an;
   assign port_pin_digital_en = q.dig_en;
   assign conversion_done_irq = q.irq;
   assign reference_ready     = q.ref_ok;
endmodule
`default_nettype wire

// [pkg/sac_pkg.sv]
// constants and carrier types of the 10-bit converter control block
package sac_pkg;
   localparam logic [15:0] SAC_ADDR_RESULT_LO = 16'hFF0E;
   localparam logic [15:0] SAC_ADDR_RESULT_HI = 16'hFF0F;
   localparam logic [15:0] SAC_ADDR_MODE      = 16'hFF80;
   localparam logic [15:0] SAC_ADDR_CHANNEL   = 16'hFF81;
   localparam logic [7:0]  SAC_MODE_RESET     = 8'h00;
   localparam logic [7:0]  SAC_CHAN_RESET     = 8'h00;
   localparam logic [15:0] SAC_RESULT_RESET   = 16'h0000;
   localparam int SAC_BIT_ENABLE   = 7;
   localparam int SAC_BIT_HWSTART  = 6;
   localparam int SAC_BIT_TIME_LO  = 3;
   localparam int SAC_BIT_EDGE_LO  = 1;
   localparam int SAC_BIT_REF      = 0;
   localparam int SAC_RES_W        = 10;
   localparam int SAC_RES_SHIFT    = 6;
   localparam int SAC_CHAN_W       = 3;
   localparam int SAC_CLK_HZ       = 50_000_000;
   localparam int SAC_REF_SETTLE_NS = 14_000;
   localparam int SAC_REF_SETTLE_CYC = (SAC_REF_SETTLE_NS * (SAC_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [9:0] SAC_LEN_144 = 10'h090;
   localparam logic [9:0] SAC_LEN_120 = 10'h078;
   localparam logic [9:0] SAC_LEN_96  = 10'h060;
   localparam logic [9:0] SAC_LEN_576 = 10'h240;
   localparam logic [9:0] SAC_LEN_480 = 10'h1E0;
   localparam logic [9:0] SAC_LEN_384 = 10'h180;
   localparam logic [9:0] SAC_SAMPLE_CYC = 10'h00C;
   localparam logic [1:0] SAC_EDGE_NONE = 2'h0;
   localparam logic [1:0] SAC_EDGE_FALL = 2'h1;
   localparam logic [1:0] SAC_EDGE_RISE = 2'h2;
   localparam logic [1:0] SAC_EDGE_BOTH = 2'h3;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        wide;
      logic        bit_op;
      logic [2:0]  bit_sel;
      logic        bit_val;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } sac_bus_req_t;

   typedef struct packed {
      logic       sample;
      logic       hold;
      logic       ref_on;
      logic [9:0] tap;
      logic [7:0] chan_onehot;
   } sac_analog_t;
endpackage
